// ==== rtl/error_status_flags_pkg.sv ====
// Constants for the error status flag bank
// Assumes one core clock, synchronous reset, plain register port
package error_status_flags_pkg;
	// ****************
	// Register map
	// ****************
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          FLAG_W        = 16;
	localparam logic [7:0]  OFF_STATUS    = 8'h00;
	localparam logic [7:0]  OFF_ENABLE    = 8'h04;
	localparam logic [7:0]  OFF_LOG_ADDR  = 8'h08;
	localparam logic [7:0]  OFF_LOG_SRC   = 8'h0C;
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h10;
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h14;
	// ****************
	// Field positions
	// ****************
	localparam int          BIT_SBE       = 0;
	localparam int          BIT_BAD_CMD   = 1;
	localparam int          BIT_BAD_ENTRY = 2;
	localparam int          BIT_MBE       = 7;
	localparam int          BIT_GLOBAL_EN = 15;
	localparam logic [15:0] FLAG_MASK     = 16'h0087;
	localparam int          LOG_ADDR_W    = 32;
	localparam int          CHAN_W        = 2;
	localparam int          DEV_W         = 3;
	localparam int          CORR_W        = 64;
	// ****************
	// Reset values
	// ****************
	localparam logic [15:0] FLAG_RST      = 16'h0000;
	localparam logic [15:0] ENABLE_RST    = 16'h0000;
endpackage

// ==== rtl/flag_if.sv ====
// Carries flag state and error log from the flag core to its users
// Assumes both ends share CLK_SYS
`timescale 1ns/10ps
interface flag_if;
	logic [error_status_flags_pkg::FLAG_W-1:0]     flags;
	logic [error_status_flags_pkg::FLAG_W-1:0]     rise;
	logic [error_status_flags_pkg::LOG_ADDR_W-1:0] log_addr;
	logic [error_status_flags_pkg::CHAN_W-1:0]     log_chan;
	logic [error_status_flags_pkg::DEV_W-1:0]      log_dev;
	modport src (output flags, rise, log_addr, log_chan, log_dev);
	modport snk (input flags, rise, log_addr, log_chan, log_dev);
endinterface

// ==== rtl/flag_core.sv ====
// Sticky error flags and the error address log with its lock
// Assumes event inputs are one-cycle pulses synchronous to clk
`timescale 1ns/10ps
module flag_core (
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire logic                              bad_entry_evt,
	input  wire logic                              bad_cmd_evt,
	input  wire logic                              sbe_evt,
	input  wire logic                              mbe_evt,
	input  wire logic [error_status_flags_pkg::LOG_ADDR_W-1:0] err_addr,
	input  wire logic [error_status_flags_pkg::CHAN_W-1:0]     err_chan,
	input  wire logic [error_status_flags_pkg::DEV_W-1:0]      err_dev,
	input  wire logic [error_status_flags_pkg::FLAG_W-1:0]     clr,
	flag_if.src                                    fo
);
	logic [error_status_flags_pkg::FLAG_W-1:0]     flags_reg, flags_next, set;
	logic [error_status_flags_pkg::LOG_ADDR_W-1:0] addr_reg, addr_next;
	logic [error_status_flags_pkg::CHAN_W-1:0]     chan_reg, chan_next;
	logic [error_status_flags_pkg::DEV_W-1:0]      dev_reg, dev_next;
	logic                              sbe_lock, mbe_lock;

	always_comb begin
		set = '0;
		set[error_status_flags_pkg::BIT_BAD_ENTRY] = bad_entry_evt;
		set[error_status_flags_pkg::BIT_BAD_CMD] = bad_cmd_evt;
		set[error_status_flags_pkg::BIT_SBE] = sbe_evt;
		set[error_status_flags_pkg::BIT_MBE] = mbe_evt;
		// Set beats a clear in the same cycle
		flags_next = ((flags_reg & ~clr) | set) & error_status_flags_pkg::FLAG_MASK;
		// A clear this cycle already releases the lock
		sbe_lock = flags_reg[error_status_flags_pkg::BIT_SBE] & ~clr[error_status_flags_pkg::BIT_SBE];
		mbe_lock = flags_reg[error_status_flags_pkg::BIT_MBE] & ~clr[error_status_flags_pkg::BIT_MBE];
		addr_next = addr_reg;
		chan_next = chan_reg;
		dev_next = dev_reg;
		if (mbe_evt && !mbe_lock) begin
			addr_next = err_addr;
			chan_next = err_chan;
			dev_next = err_dev;
		end else if (sbe_evt && !sbe_lock && !mbe_lock) begin
			addr_next = err_addr;
			chan_next = err_chan;
			dev_next = err_dev;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_reg <= error_status_flags_pkg::FLAG_RST;
			addr_reg <= '0;
			chan_reg <= '0;
			dev_reg <= '0;
		end else begin
			flags_reg <= flags_next;
			addr_reg <= addr_next;
			chan_reg <= chan_next;
			dev_reg <= dev_next;
		end
	end

	assign fo.flags = flags_reg;
	assign fo.rise = flags_next & ~flags_reg;
	assign fo.log_addr = addr_reg;
	assign fo.log_chan = chan_reg;
	assign fo.log_dev = dev_reg;
endmodule // flag_core

// ==== rtl/serr_msg.sv ====
// Hub-link system error message on rising, enabled flags
// Assumes enable word lays out like the flag word, global enable at top
`timescale 1ns/10ps
module serr_msg (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [error_status_flags_pkg::FLAG_W-1:0] enable,
	flag_if.snk                                fi,
	output logic                               msg
);
	logic msg_reg, msg_next;

	always_comb begin
		// Several rising flags in one cycle merge into one message
		msg_next = enable[error_status_flags_pkg::BIT_GLOBAL_EN] &
			(|(fi.rise & enable & error_status_flags_pkg::FLAG_MASK));
	end

	always_ff @(posedge clk) begin
		if (rst)
			msg_reg <= 1'b0;
		else
			msg_reg <= msg_next;
	end

	assign msg = msg_reg;
endmodule // serr_msg

// ==== rtl/error_status_bank.sv ====
// Top of the error status flag bank: register port, interrupt, messages
// Assumes register strobes are one cycle and never both high
`timescale 1ns/10ps
module error_status_bank (
	input  wire logic                              CLK_SYS,
	input  wire logic                              RST,
	input  wire logic [error_status_flags_pkg::ADDR_W-1:0]     ADDR,
	input  wire logic [error_status_flags_pkg::DATA_W-1:0]     WDATA,
	input  wire logic                              WR,
	input  wire logic                              RD,
	output logic      [error_status_flags_pkg::DATA_W-1:0]     RDATA,
	input  wire logic                              BAD_ENTRY_EVT,
	input  wire logic                              BAD_CMD_EVT,
	input  wire logic                              SBE_EVT,
	input  wire logic                              MBE_EVT,
	input  wire logic [error_status_flags_pkg::LOG_ADDR_W-1:0] ERR_ADDR,
	input  wire logic [error_status_flags_pkg::CHAN_W-1:0]     ERR_CHAN,
	input  wire logic [error_status_flags_pkg::DEV_W-1:0]      ERR_DEV,
	input  wire logic [error_status_flags_pkg::CORR_W-1:0]     CORR_DATA,
	input  wire logic                              CORR_VALID,
	output logic      [error_status_flags_pkg::CORR_W-1:0]     READ_DATA,
	output logic                                   READ_VALID,
	output logic                                   SERR_MSG,
	output logic                                   IRQ
);
	// ****************
	// Decode
	// ****************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	flag_if fl ();

	logic [error_status_flags_pkg::FLAG_W-1:0]  clr;
	logic [error_status_flags_pkg::FLAG_W-1:0]  enable_reg, enable_next;
	logic [error_status_flags_pkg::FLAG_W-1:0]  irq_stat_reg, irq_stat_next;
	logic [error_status_flags_pkg::FLAG_W-1:0]  irq_mask_reg, irq_mask_next;
	logic                           irq_reg, irq_next;
	logic [error_status_flags_pkg::DATA_W-1:0]  rdata_reg, rdata_next;
	logic [error_status_flags_pkg::CORR_W-1:0]  rd_data_reg, rd_data_next;
	logic                           rd_valid_reg, rd_valid_next;
	logic                           wr_status, wr_enable, wr_mask, rd_irq;

	// ****************
	// Flag core
	// ****************
	always_comb begin
		wr_status = WR & hit(ADDR, error_status_flags_pkg::OFF_STATUS);
		wr_enable = WR & hit(ADDR, error_status_flags_pkg::OFF_ENABLE);
		wr_mask = WR & hit(ADDR, error_status_flags_pkg::OFF_IRQ_MASK);
		rd_irq = RD & hit(ADDR, error_status_flags_pkg::OFF_IRQ_STAT);
		clr = wr_status ? WDATA[error_status_flags_pkg::FLAG_W-1:0] : '0;
	end

	flag_core u_core (
		.clk           (CLK_SYS),
		.rst           (RST),
		.bad_entry_evt (BAD_ENTRY_EVT),
		.bad_cmd_evt   (BAD_CMD_EVT),
		.sbe_evt       (SBE_EVT),
		.mbe_evt       (MBE_EVT),
		.err_addr      (ERR_ADDR),
		.err_chan      (ERR_CHAN),
		.err_dev       (ERR_DEV),
		.clr           (clr),
		.fo            (fl)
	);

	serr_msg u_serr (
		.clk    (CLK_SYS),
		.rst    (RST),
		.enable (enable_reg),
		.fi     (fl),
		.msg    (SERR_MSG)
	);

	// ****************
	// Registers and interrupt
	// ****************
	always_comb begin
		enable_next = wr_enable ? WDATA[error_status_flags_pkg::FLAG_W-1:0] : enable_reg;
		irq_mask_next = wr_mask ? WDATA[error_status_flags_pkg::FLAG_W-1:0] : irq_mask_reg;
		// Read clears, a new rise in the same cycle survives
		irq_stat_next = ((rd_irq ? '0 : irq_stat_reg) | fl.rise) & error_status_flags_pkg::FLAG_MASK;
		irq_next = |(irq_stat_next & irq_mask_next);
		rdata_next = '0;
		if (RD) begin
			case (ADDR)
				error_status_flags_pkg::OFF_STATUS:   rdata_next = {16'h0000, fl.flags};
				error_status_flags_pkg::OFF_ENABLE:   rdata_next = {16'h0000, enable_reg};
				error_status_flags_pkg::OFF_LOG_ADDR: rdata_next = fl.log_addr;
				error_status_flags_pkg::OFF_LOG_SRC:  rdata_next = {27'h0000000, fl.log_dev, fl.log_chan};
				error_status_flags_pkg::OFF_IRQ_STAT: rdata_next = {16'h0000, irq_stat_reg};
				error_status_flags_pkg::OFF_IRQ_MASK: rdata_next = {16'h0000, irq_mask_reg};
				default:                  rdata_next = '0;
			endcase
		end
		// Corrected data flows on regardless of the flag
		rd_data_next = CORR_DATA;
		rd_valid_next = CORR_VALID;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			enable_reg <= error_status_flags_pkg::ENABLE_RST;
			irq_stat_reg <= error_status_flags_pkg::FLAG_RST;
			irq_mask_reg <= error_status_flags_pkg::FLAG_RST;
			irq_reg <= 1'b0;
			rdata_reg <= '0;
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			enable_reg <= enable_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign RDATA = rdata_reg;
	assign IRQ = irq_reg;
	assign READ_DATA = rd_data_reg;
	assign READ_VALID = rd_valid_reg;

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge CLK_SYS); endclocking

	logic [error_status_flags_pkg::LOG_ADDR_W-1:0] log_a;
	logic                              sbe_f, mbe_f, clr0, clr7;
	assign log_a = fl.log_addr;
	assign sbe_f = fl.flags[error_status_flags_pkg::BIT_SBE];
	assign mbe_f = fl.flags[error_status_flags_pkg::BIT_MBE];
	assign clr0 = clr[error_status_flags_pkg::BIT_SBE];
	assign clr7 = clr[error_status_flags_pkg::BIT_MBE];

	sequence s_sbe_held;
		sbe_f && !clr0 && !mbe_f && !MBE_EVT;
	endsequence

	sequence s_mbe_over_sbe;
		sbe_f && !clr0 && !mbe_f && MBE_EVT;
	endsequence

	a_bad_entry_set: assert property (disable iff (RST)
		BAD_ENTRY_EVT |=> fl.flags[error_status_flags_pkg::BIT_BAD_ENTRY])
		else $error("bad entry flag not set");
	a_bad_cmd_set: assert property (disable iff (RST)
		BAD_CMD_EVT |=> fl.flags[error_status_flags_pkg::BIT_BAD_CMD])
		else $error("bad command flag not set");
	a_one_clears: assert property (disable iff (RST)
		wr_status && WDATA[error_status_flags_pkg::BIT_BAD_CMD] && !BAD_CMD_EVT
		|=> !fl.flags[error_status_flags_pkg::BIT_BAD_CMD])
		else $error("write one did not clear flag");
	a_zero_keeps: assert property (disable iff (RST)
		fl.flags[error_status_flags_pkg::BIT_BAD_ENTRY] && !clr[error_status_flags_pkg::BIT_BAD_ENTRY]
		|=> fl.flags[error_status_flags_pkg::BIT_BAD_ENTRY])
		else $error("flag lost without a clear");
	a_sbe_set: assert property (disable iff (RST)
		SBE_EVT |=> sbe_f ##1 READ_VALID == $past(CORR_VALID))
		else $error("single-bit flag or data path wrong");
	a_sbe_capture: assert property (disable iff (RST)
		SBE_EVT && !MBE_EVT && !(sbe_f && !clr0) && !(mbe_f && !clr7)
		|=> log_a == $past(ERR_ADDR) && fl.log_chan == $past(ERR_CHAN))
		else $error("single-bit error not logged");
	a_sbe_locked: assert property (disable iff (RST)
		s_sbe_held |=> $stable(log_a) && $stable(fl.log_dev))
		else $error("log changed while locked");
	a_mbe_overwrite: assert property (disable iff (RST)
		s_mbe_over_sbe |=> log_a == $past(ERR_ADDR) && mbe_f && sbe_f)
		else $error("multiple-bit overwrite failed");
	a_mbe_lock: assert property (disable iff (RST)
		mbe_f && !clr7 |=> mbe_f && $stable(log_a))
		else $error("multiple-bit lock broken");
	a_same_cycle: assert property (disable iff (RST)
		SBE_EVT && MBE_EVT && !(mbe_f && !clr7) |=> log_a == $past(ERR_ADDR) && mbe_f)
		else $error("multiple-bit not given priority");
	a_serr_send: assert property (disable iff (RST)
		|(fl.rise & enable_reg & error_status_flags_pkg::FLAG_MASK) && enable_reg[error_status_flags_pkg::BIT_GLOBAL_EN]
		|=> SERR_MSG)
		else $error("message not sent");
	a_serr_quiet: assert property (disable iff (RST)
		!enable_reg[error_status_flags_pkg::BIT_GLOBAL_EN] |=> !SERR_MSG)
		else $error("message sent while disabled");
	a_set_unenabled: assert property (disable iff (RST)
		SBE_EVT && enable_reg == 16'h0000 |=> sbe_f)
		else $error("flag gated by enable");
	a_reset_clean: assert property (
		RST |=> fl.flags == 16'h0000 && !SERR_MSG && !IRQ)
		else $error("reset state wrong");
endmodule // error_status_bank

// ==== verification/hub_partner.sv ====
// Hub-side receiver model: counts system error message requests
// Assumes msg is a one-cycle pulse synchronous to clk
`timescale 1ns/10ps
module hub_partner (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       msg,
	output logic      [7:0] msg_count
);
	// ****************
	// Receiver
	// ****************
	// One count per high cycle, so a stuck level shows as extra messages
	always_ff @(posedge clk) begin
		if (rst) begin
			msg_count <= 8'h00;
		end else if (msg) begin
			msg_count <= msg_count + 8'h01;
		end
	end
endmodule // hub_partner

// ==== verification/error_status_bank_tb_top.sv ====
// Self-checking bench for the error status flag bank
// Assumes error_status_flags_pkg, flag_if, design modules and hub_partner compiled first
`timescale 1ns/10ps
module error_status_bank_tb_top;
	// ****************
	// Signals
	// ****************
	logic        CLK_SYS, RST, WR, RD, CORR_VALID, READ_VALID, SERR_MSG, IRQ;
	logic        BAD_ENTRY_EVT, BAD_CMD_EVT, SBE_EVT, MBE_EVT;
	logic [7:0]  ADDR, msg_count;
	logic [31:0] WDATA, RDATA, ERR_ADDR;
	logic [1:0]  ERR_CHAN;
	logic [2:0]  ERR_DEV;
	logic [63:0] CORR_DATA, READ_DATA;
	int          n_errors = 0;
	int          checks = 0;
	error_status_bank error_status_bank_i (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .BAD_ENTRY_EVT(BAD_ENTRY_EVT), .BAD_CMD_EVT(BAD_CMD_EVT),
		.SBE_EVT(SBE_EVT), .MBE_EVT(MBE_EVT), .ERR_ADDR(ERR_ADDR), .ERR_CHAN(ERR_CHAN), .ERR_DEV(ERR_DEV),
		.CORR_DATA(CORR_DATA), .CORR_VALID(CORR_VALID), .READ_DATA(READ_DATA), .READ_VALID(READ_VALID),
		.SERR_MSG(SERR_MSG), .IRQ(IRQ));
	hub_partner hub_partner_i (.clk(CLK_SYS), .rst(RST), .msg(SERR_MSG), .msg_count(msg_count));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1;
		chk(what, {32'h0, RDATA}, {32'h0, exp});
	endtask
	// k = {multi, single, command, entry}; corrected data rides along
	task automatic ev(input logic [3:0] k, input logic [31:0] a, input logic [1:0] c, input logic [2:0] d);
		@(posedge CLK_SYS);
		{MBE_EVT, SBE_EVT, BAD_CMD_EVT, BAD_ENTRY_EVT} <= k;
		ERR_ADDR <= a;
		ERR_CHAN <= c;
		ERR_DEV <= d;
		CORR_DATA <= {a, ~a};
		CORR_VALID <= 1'b1;
		@(posedge CLK_SYS);
		{MBE_EVT, SBE_EVT, BAD_CMD_EVT, BAD_ENTRY_EVT} <= 4'h0;
		ERR_ADDR <= ~a;
		ERR_CHAN <= ~c;
		ERR_DEV <= ~d;
		CORR_VALID <= 1'b0;
		#1;
		chk("read_data", READ_DATA, {a, ~a});
		chk("read_valid", {63'h0, READ_VALID}, 64'h1);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ****************
	// Clock, watchdog, tests
	// ****************
	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end
	// Tests need about a hundred cycles; thirty times that means a hang
	initial begin
		repeat (3000) @(posedge CLK_SYS);
		n_errors++;
		$display("watchdog expired");
		give_verdict();
	end
	initial begin
		{RST, WR, RD, CORR_VALID, BAD_ENTRY_EVT, BAD_CMD_EVT, SBE_EVT, MBE_EVT} = 8'hFF;
		{WR, RD, CORR_VALID, BAD_ENTRY_EVT, BAD_CMD_EVT, SBE_EVT, MBE_EVT} = 7'h00;
		{ADDR, WDATA, ERR_ADDR, ERR_CHAN, ERR_DEV, CORR_DATA} = '0;
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'b0;
		rc("status", 8'h00, 32'h0);
		rc("log_addr", 8'h08, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		rc("unmapped", 8'h20, 32'h0);
		$display("test reset done");
		ev(4'h2, 32'h0, 2'h0, 3'h0);
		rc("status", 8'h00, 32'h2);
		chk("msg_count", {56'h0, msg_count}, 64'h0);
		wr(8'h00, 32'h2);
		wr(8'h04, 32'h8087);
		wr(8'h14, 32'h0087);
		ev(4'h1, 32'h0, 2'h0, 3'h0);
		chk("irq", {63'h0, IRQ}, 64'h1);
		rc("status", 8'h00, 32'h4);
		chk("msg_count", {56'h0, msg_count}, 64'h1);
		wr(8'h00, 32'h0);
		rc("status", 8'h00, 32'h4);
		wr(8'h00, 32'h4);
		rc("status", 8'h00, 32'h0);
		rc("enable", 8'h04, 32'h8087);
		rc("irq_mask", 8'h14, 32'h87);
		rc("irq_stat", 8'h10, 32'h6);
		rc("irq_stat", 8'h10, 32'h0);
		chk("irq", {63'h0, IRQ}, 64'h0);
		wr(8'h14, 32'h0);
		ev(4'h2, 32'h0, 2'h0, 3'h0);
		rc("status", 8'h00, 32'h2);
		chk("irq", {63'h0, IRQ}, 64'h0);
		chk("msg_count", {56'h0, msg_count}, 64'h2);
		wr(8'h00, 32'h2);
		wr(8'h14, 32'h0087);
		$display("test flags done");
		ev(4'h4, 32'hA1A1_0010, 2'h1, 3'h5);
		rc("status", 8'h00, 32'h1);
		rc("log_addr", 8'h08, 32'hA1A1_0010);
		rc("log_src", 8'h0C, 32'h15);
		ev(4'h4, 32'hB2B2_0020, 2'h2, 3'h3);
		rc("log_addr", 8'h08, 32'hA1A1_0010);
		chk("msg_count", {56'h0, msg_count}, 64'h3);
		ev(4'h8, 32'hC3C3_0030, 2'h3, 3'h6);
		rc("status", 8'h00, 32'h81);
		rc("log_addr", 8'h08, 32'hC3C3_0030);
		rc("log_src", 8'h0C, 32'h1B);
		ev(4'h4, 32'hD4D4_0040, 2'h0, 3'h1);
		rc("log_addr", 8'h08, 32'hC3C3_0030);
		chk("msg_count", {56'h0, msg_count}, 64'h4);
		wr(8'h00, 32'h81);
		rc("status", 8'h00, 32'h0);
		ev(4'h4, 32'hE5E5_0050, 2'h0, 3'h1);
		rc("log_addr", 8'h08, 32'hE5E5_0050);
		wr(8'h00, 32'h1);
		ev(4'hC, 32'hF6F6_0060, 2'h2, 3'h2);
		rc("status", 8'h00, 32'h81);
		rc("log_src", 8'h0C, 32'h0A);
		chk("msg_count", {56'h0, msg_count}, 64'h6);
		wr(8'h00, 32'h81);
		$display("test ecc log done");
		give_verdict();
	end
endmodule // error_status_bank_tb_top
